// ---- logic/eqs_pkg.sv ----
// Purpose: shared constants, types and helpers of the egress queue scheduler
// Assumes: one egress port with eight queues and eight priorities
// Notes: widths are fixed; buffer size default is a plain value
package eqs_pkg;
  localparam int NQ = 8;
  localparam int NP = 8;
  localparam int QW = 3;
  localparam int PW = 3;
  localparam int BYTE_W = 16;
  localparam int CELL_W = 11;
  localparam int PKT_W = 10;
  localparam int BKT_W = 24;
  localparam int WGT_W = 8;
  localparam int CNT_W = 32;
  localparam int POS_W = 5;
  localparam logic [CELL_W-1:0] TOTAL_CELLS = 11'h400;
  localparam logic [BKT_W-1:0] BKT_RESET = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h00000001;
  localparam logic [PKT_W-1:0] PKT_ONE = 10'h001;

  typedef enum logic {EQS_OP_SEND, EQS_OP_DROP} eqs_op_t;

  typedef struct packed {
    eqs_op_t op;
    logic [QW-1:0] queue;
  } eqs_cmd_t;

  typedef struct packed {
    logic [BYTE_W-1:0] bytes;
    logic [CELL_W-1:0] cells;
  } eqs_done_t;

  typedef struct packed {
    logic [QW-1:0] queue;
    logic [CELL_W-1:0] cells;
  } eqs_enq_t;

  // index of the highest set bit, zero for a zero value
  function automatic logic [POS_W-1:0] top_one_position(
      input logic [BYTE_W-1:0] v);
    logic [POS_W-1:0] r;
    r = '0;
    for (int i = 0; i < BYTE_W; i++) begin
      if (v[i]) begin
        r = POS_W'(i);
      end
    end
    return r;
  endfunction
endpackage

// ---- logic/eqs_bucket.sv ----
// Purpose: one deficit byte bucket with charge, refill and cap
// Assumes: charge and refill may coincide; both apply in one step
// Notes: level is signed so a large packet may drive it negative
`timescale 1ns/1ps
module eqs_bucket
  import eqs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic charge,
  input wire logic [BKT_W-1:0] charge_amt,
  input wire logic refill,
  input wire logic [BKT_W-1:0] add_amt,
  input wire logic signed [BKT_W-1:0] cap,
  output logic signed [BKT_W-1:0] level
);
  logic signed [BKT_W-1:0] level_q;
  logic signed [BKT_W-1:0] level_d;
  logic signed [BKT_W-1:0] sum;

  always_comb begin
    sum = level_q;
    if (charge) begin
      sum = sum - $signed(charge_amt);
    end
    if (refill) begin
      sum = sum + $signed(add_amt);
    end
    level_d = (sum > cap) ? cap : sum;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= BKT_RESET;
    end else begin
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule

// ---- logic/eqs_pick.sv ----
// Purpose: strict priority then largest bucket queue choice
// Assumes: candidate and priority readiness come from the caller
// Notes: ties go to the lowest queue index
`timescale 1ns/1ps
module eqs_pick
  import eqs_pkg::*;
(
  input wire logic [NQ-1:0] cand,
  input wire logic [NQ-1:0][PW-1:0] qprio,
  input wire logic [NP-1:0] prio_ok,
  input wire logic signed [BKT_W-1:0] level [NQ],
  output logic found,
  output logic [QW-1:0] queue
);
  logic [NP-1:0] prio_has;
  logic [NP-1:0] prio_elig;
  logic [PW-1:0] win_p;
  logic signed [BKT_W-1:0] best;
  logic have;

  always_comb begin
    prio_has = '0;
    for (int q = 0; q < NQ; q++) begin
      if (cand[q]) begin
        prio_has[qprio[q]] = 1'b1;
      end
    end
    prio_elig = prio_has & prio_ok;
    win_p = '0;
    found = |prio_elig;
    // priority zero is most urgent, so scan from the top down
    for (int p = NP - 1; p >= 0; p--) begin
      if (prio_elig[p]) begin
        win_p = PW'(p);
      end
    end
    queue = '0;
    best = '0;
    have = 1'b0;
    // first member seeds the search, so negative buckets compare right
    for (int q = 0; q < NQ; q++) begin
      if (cand[q] && qprio[q] == win_p && (!have || level[q] > best)) begin
        have = 1'b1;
        best = level[q];
        queue = QW'(q);
      end
    end
  end
endmodule

// ---- logic/eqs_top.sv ----
// Purpose: egress queue scheduler and queue manager for one port
// Assumes: packet storage lives outside; it frees a packet on each
//   command and answers with the packet's bytes and cells
// Notes: no register bus; configuration and status are plain ports
// How it works
// - two stages: strict priority first, then round robin inside it
// - priority eligible with a ready queue, shaper ok, not paused or halted
// - highest eligible priority wins, then the deficit round robin picks
// - one byte bucket per queue, compared only inside one priority
// - among queues holding data, the largest bucket wins
// - a sent packet's byte length leaves its queue's bucket
// - the interframe gap bytes are also taken per sent packet
// - a bucket under threshold refills all buckets of its priority
// - refill shift is cell size top bit minus weight top bit, floor 0
// - buckets never pass the capacity, so idle buckets saturate
// - disabled queues start nothing new but keep their packets
// - enqueue to a disabled queue is dropped and counted
// - drain discards all queued packets of the port and counts them
// - per-port depth, per-queue depth and free cells are readable
// - low-water mark of free cells since reset is kept
// - port empty status is high exactly when every queue is empty
// - data already handed downstream still goes out after empty
// - each queue maps to one of eight priorities, any count per priority
// - priority zero is most urgent, seven least
// - queue is a candidate only with a packet and its shaper ok
`timescale 1ns/1ps
module eqs_top
  import eqs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [NQ-1:0][PW-1:0] queue_prio,
  input wire logic [NQ-1:0][WGT_W-1:0] queue_weight,
  input wire logic signed [BKT_W-1:0] refill_threshold,
  input wire logic [WGT_W-1:0] ifg_bytes,
  input wire logic signed [BKT_W-1:0] bucket_cap,
  input wire logic [BYTE_W-1:0] cell_size_bytes,
  input wire logic [NQ-1:0] sched_disable,
  input wire logic [NQ-1:0] enq_enable,
  input wire logic drain_req,
  input wire logic [NQ-1:0] queue_shaper_ok,
  input wire logic [NP-1:0] prio_shaper_ok,
  input wire logic [NP-1:0] prio_pause,
  input wire logic [NP-1:0] prio_halt,
  input wire logic enq_valid,
  input wire eqs_enq_t enq,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output eqs_cmd_t cmd,
  input wire logic done_valid,
  input wire eqs_done_t done,
  output logic [NQ-1:0][PKT_W-1:0] queue_depth,
  output logic [PKT_W+QW-1:0] port_depth,
  output logic [CELL_W-1:0] free_cells,
  output logic [CELL_W-1:0] min_free_cells,
  output logic port_empty,
  output logic [CNT_W-1:0] qoff_drop_cnt,
  output logic [CNT_W-1:0] drain_drop_cnt
);
  typedef enum logic [1:0] {ST_IDLE, ST_OFFER, ST_BUSY} eqs_state_t;

  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  eqs_state_t state_q;
  eqs_state_t state_d;
  eqs_cmd_t cmd_q;
  eqs_cmd_t cmd_d;
  logic [NQ-1:0][PKT_W-1:0] pkts_q;
  logic [NQ-1:0][PKT_W-1:0] pkts_d;
  logic [NQ-1:0][CELL_W-1:0] cells_q;
  logic [NQ-1:0][CELL_W-1:0] cells_d;
  logic [CELL_W-1:0] min_free_q;
  logic [CELL_W-1:0] min_free_d;
  logic [CNT_W-1:0] qoff_q;
  logic [CNT_W-1:0] qoff_d;
  logic [CNT_W-1:0] drain_cnt_q;
  logic [CNT_W-1:0] drain_cnt_d;
  logic [CELL_W-1:0] free_q;
  logic [CELL_W-1:0] free_d;
  logic [PKT_W+QW-1:0] depth_q;
  logic [PKT_W+QW-1:0] depth_d;
  logic empty_q;
  logic empty_d;

  logic signed [BKT_W-1:0] level [NQ];
  logic [NQ-1:0] has_pkt;
  logic [NQ-1:0] cand;
  logic [NP-1:0] prio_ok;
  logic found;
  logic [QW-1:0] pick_q_idx;
  logic [QW-1:0] drop_q_idx;
  logic [NQ-1:0] charge;
  logic [NQ-1:0] refill;
  logic [NP-1:0] prio_refill;
  logic [NP-1:0][WGT_W-1:0] trig_w;
  logic [NP-1:0][POS_W-1:0] shift_x;
  logic [NQ-1:0][BKT_W-1:0] add_amt;
  logic [BKT_W-1:0] charge_amt;
  logic [CELL_W-1:0] used_cells;
  logic [PKT_W+QW-1:0] pkt_sum;
  logic done_send;

  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      has_pkt[q] = pkts_q[q] != '0;
    end
  end
  // disabled queues just stop being candidates; packets stay
  assign cand = has_pkt & queue_shaper_ok & ~sched_disable;
  assign prio_ok = prio_shaper_ok & ~prio_pause & ~prio_halt;

  eqs_pick u_pick (
    .cand(cand),
    .qprio(queue_prio),
    .prio_ok(prio_ok),
    .level(level),
    .found(found),
    .queue(pick_q_idx)
  );

  // drain ignores eligibility: lowest non-empty queue goes first
  always_comb begin
    drop_q_idx = '0;
    for (int q = NQ - 1; q >= 0; q--) begin
      if (has_pkt[q]) begin
        drop_q_idx = QW'(q);
      end
    end
  end

  // refill trigger and shift per priority group
  always_comb begin
    prio_refill = '0;
    trig_w = '0;
    for (int q = NQ - 1; q >= 0; q--) begin
      if (level[q] < refill_threshold) begin
        prio_refill[queue_prio[q]] = 1'b1;
        trig_w[queue_prio[q]] = queue_weight[q];
      end
    end
    for (int p = 0; p < NP; p++) begin
      // shift sized so the starving queue gains more than half a cell
      if (top_one_position(cell_size_bytes) >
          top_one_position(BYTE_W'(trig_w[p]))) begin
        shift_x[p] = top_one_position(cell_size_bytes) -
                     top_one_position(BYTE_W'(trig_w[p]));
      end else begin
        shift_x[p] = '0;
      end
    end
    for (int q = 0; q < NQ; q++) begin
      refill[q] = prio_refill[queue_prio[q]];
      add_amt[q] = BKT_W'(queue_weight[q]) << shift_x[queue_prio[q]];
    end
  end

  assign done_send = done_valid && state_q == ST_BUSY &&
                     cmd_q.op == EQS_OP_SEND;
  assign charge_amt = BKT_W'(done.bytes) + BKT_W'(ifg_bytes);

  genvar gq;
  generate
    for (gq = 0; gq < NQ; gq++) begin : g_bkt
      assign charge[gq] = done_send && cmd_q.queue == QW'(gq);
      eqs_bucket u_bkt (
        .clk(clk),
        .rst_b(rst_n),
        .charge(charge[gq]),
        .charge_amt(charge_amt),
        .refill(refill[gq]),
        .add_amt(add_amt[gq]),
        .cap(bucket_cap),
        .level(level[gq])
      );
    end
  endgenerate

  // one command in flight; a new choice waits for the packet's done
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    unique case (state_q)
      ST_IDLE: begin
        if (drain_req && |has_pkt) begin
          cmd_d.op = EQS_OP_DROP;
          cmd_d.queue = drop_q_idx;
          state_d = ST_OFFER;
        end else if (found) begin
          cmd_d.op = EQS_OP_SEND;
          cmd_d.queue = pick_q_idx;
          state_d = ST_OFFER;
        end
      end
      ST_OFFER: begin
        if (cmd_ready) begin
          state_d = ST_BUSY;
        end
      end
      ST_BUSY: begin
        // started packet finishes whatever eligibility does now
        if (done_valid) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    pkts_d = pkts_q;
    cells_d = cells_q;
    qoff_d = qoff_q;
    drain_cnt_d = drain_cnt_q;
    if (enq_valid) begin
      if (enq_enable[enq.queue]) begin
        pkts_d[enq.queue] = pkts_d[enq.queue] + PKT_ONE;
        cells_d[enq.queue] = cells_d[enq.queue] + enq.cells;
      end else begin
        qoff_d = qoff_q + CNT_ONE;
      end
    end
    if (done_valid && state_q == ST_BUSY) begin
      pkts_d[cmd_q.queue] = pkts_d[cmd_q.queue] - PKT_ONE;
      cells_d[cmd_q.queue] = cells_d[cmd_q.queue] - done.cells;
      if (cmd_q.op == EQS_OP_DROP) begin
        drain_cnt_d = drain_cnt_q + CNT_ONE;
      end
    end
  end

  always_comb begin
    used_cells = '0;
    pkt_sum = '0;
    for (int q = 0; q < NQ; q++) begin
      used_cells = used_cells + cells_d[q];
      pkt_sum = pkt_sum + (PKT_W + QW)'(pkts_d[q]);
    end
  end
  // status built from next counts, so flops add no lag to it
  assign free_d = TOTAL_CELLS - used_cells;
  assign depth_d = pkt_sum;
  assign empty_d = ~|pkts_d;
  assign min_free_d = (free_d < min_free_q) ? free_d : min_free_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      pkts_q <= '0;
      cells_q <= '0;
      min_free_q <= TOTAL_CELLS;
      free_q <= TOTAL_CELLS;
      depth_q <= '0;
      empty_q <= 1'b1;
      qoff_q <= '0;
      drain_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      pkts_q <= pkts_d;
      cells_q <= cells_d;
      min_free_q <= min_free_d;
      free_q <= free_d;
      depth_q <= depth_d;
      empty_q <= empty_d;
      qoff_q <= qoff_d;
      drain_cnt_q <= drain_cnt_d;
    end
  end

  assign cmd_valid = state_q == ST_OFFER;
  assign cmd = cmd_q;
  assign queue_depth = pkts_q;
  assign port_depth = depth_q;
  assign free_cells = free_q;
  assign min_free_cells = min_free_q;
  // software polls this after stopping enqueue and draining
  assign port_empty = empty_q;
  assign qoff_drop_cnt = qoff_q;
  assign drain_drop_cnt = drain_cnt_q;
endmodule

// ---- dv/eqs_chk.sv ----
// Purpose: port checks of eqs_top
// Assumes: one clock, choices use inputs one edge before the offer
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module eqs_chk
  import eqs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [NQ-1:0] sched_disable,
  input wire logic [NQ-1:0] queue_shaper_ok,
  input wire logic [NQ-1:0] enq_enable,
  input wire logic drain_req,
  input wire logic enq_valid,
  input wire eqs_enq_t enq,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire eqs_cmd_t cmd,
  input wire logic done_valid,
  input wire logic [NQ-1:0][PKT_W-1:0] queue_depth,
  input wire logic [PKT_W+QW-1:0] port_depth,
  input wire logic [CELL_W-1:0] free_cells,
  input wire logic [CELL_W-1:0] min_free_cells,
  input wire logic port_empty,
  input wire logic [CNT_W-1:0] qoff_drop_cnt
);
  logic [NQ-1:0] dis_q;
  logic [NQ-1:0] shp_q;
  always_ff @(posedge clk) begin
    dis_q <= sched_disable;
    shp_q <= queue_shaper_ok;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_empty;
    port_empty == (port_depth == '0);
  endproperty
  a_empty: assert property (p_empty) else $error("empty flag");
  property p_full;
    port_empty |-> free_cells == TOTAL_CELLS;
  endproperty
  a_full: assert property (p_full) else $error("free count");
  property p_low;
    min_free_cells <= free_cells;
  endproperty
  a_low: assert property (p_low) else $error("low mark");
  property p_lowmono;
    min_free_cells <= $past(min_free_cells);
  endproperty
  a_lowmono: assert property (p_lowmono) else $error("low rose");
  property p_qoff;
    enq_valid && !enq_enable[enq.queue] |=>
      qoff_drop_cnt == $past(qoff_drop_cnt) + CNT_ONE;
  endproperty
  a_qoff: assert property (p_qoff) else $error("qoff count");
  property p_enq;
    enq_valid && enq_enable[enq.queue] && !done_valid |=>
      queue_depth[$past(enq.queue)] == $past(queue_depth[enq.queue]) + PKT_ONE;
  endproperty
  a_enq: assert property (p_enq) else $error("depth step");
  property p_hold;
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd);
  endproperty
  a_hold: assert property (p_hold) else $error("offer moved");
  property p_busy;
    cmd_valid && cmd_ready |=> !cmd_valid;
  endproperty
  a_busy: assert property (p_busy) else $error("second offer");
  property p_gap;
    done_valid |=> !cmd_valid;
  endproperty
  a_gap: assert property (p_gap) else $error("no idle gap");
  property p_drain;
    $rose(cmd_valid) && $past(drain_req) && $past(drain_req, 2) |->
      cmd.op == EQS_OP_DROP;
  endproperty
  a_drain: assert property (p_drain) else $error("send in drain");
  property p_send;
    $rose(cmd_valid) && cmd.op == EQS_OP_SEND |->
      !dis_q[cmd.queue] && shp_q[cmd.queue] && queue_depth[cmd.queue] != '0;
  endproperty
  a_send: assert property (p_send) else $error("bad send");
endmodule

bind eqs_top eqs_chk i_chk (.clk(clk), .rst_b(rst_b),
  .sched_disable(sched_disable), .queue_shaper_ok(queue_shaper_ok),
  .enq_enable(enq_enable), .drain_req(drain_req), .enq_valid(enq_valid),
  .enq(enq), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
  .done_valid(done_valid), .queue_depth(queue_depth),
  .port_depth(port_depth), .free_cells(free_cells),
  .min_free_cells(min_free_cells), .port_empty(port_empty),
  .qoff_drop_cnt(qoff_drop_cnt));

// ---- dv/eqs_store.sv ----
// Purpose: packet store and pipeline on the far side of eqs_top
// Assumes: a packet of queue q holds q+1 cells of 64 bytes
// Notes: slow stretches the answer; idle answer bus toggles
`timescale 1ns/1ps
module eqs_store
  import eqs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire eqs_cmd_t cmd,
  output logic done_valid,
  output eqs_done_t done
);
  logic [2:0] wt_q;
  logic [QW-1:0] cq_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ready <= 1'b0;
      done_valid <= 1'b0;
      done <= '0;
      wt_q <= 3'h0;
      cq_q <= '0;
    end else begin
      done_valid <= 1'b0;
      done <= ~done; // a stale answer never looks valid
      if (cmd_valid && cmd_ready) begin
        cmd_ready <= 1'b0;
        cq_q <= cmd.queue;
        wt_q <= slow ? 3'h4 : 3'h1;
      end else if (wt_q == 3'h1) begin
        done_valid <= 1'b1;
        done <= {BYTE_W'(cq_q + 1) << 6, CELL_W'(cq_q + 1)};
        wt_q <= 3'h0;
      end else if (wt_q != 3'h0) begin
        wt_q <= wt_q - 3'h1;
      end else if (cmd_valid) begin
        cmd_ready <= 1'b1;
      end
    end
  end
endmodule

// ---- dv/eqs_top_tb.sv ----
// Purpose: self-checking bench of eqs_top
// Assumes: queue q packets are q+1 cells, store model answers
// Notes: choice checks run only while the setup stands still
`timescale 1ns/1ps
module eqs_top_tb;
  import eqs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic slow = 1'b0;
  logic [NQ-1:0][PW-1:0] queue_prio = '0;
  logic [NQ-1:0] sched_disable = 8'hff;
  logic [NQ-1:0] enq_enable = 8'hff;
  logic drain_req = 1'b0;
  logic [NQ-1:0] queue_shaper_ok = 8'hff;
  logic [NP-1:0] prio_shaper_ok = 8'hff;
  logic [NP-1:0] prio_pause = 8'h00;
  logic [NP-1:0] prio_halt = 8'h00;
  logic enq_valid = 1'b0;
  eqs_enq_t enq = '0;
  logic cmd_valid, cmd_ready, done_valid, port_empty;
  eqs_cmd_t cmd;
  eqs_done_t done;
  logic [NQ-1:0][PKT_W-1:0] queue_depth;
  logic [PKT_W+QW-1:0] port_depth;
  logic [CELL_W-1:0] free_cells, min_free_cells;
  logic [CNT_W-1:0] qoff_drop_cnt, drain_drop_cnt;
  int fail_count = 0;
  int tests_run = 0;
  int dep[NQ] = '{default: 0};
  int qoff = 0;
  int dd = 0;
  int mn = 1024;
  int rot = 0;
  bit chk_on = 1'b0;
  logic [QW-1:0] seen[$];
  always #2.5 clk = ~clk;
  always @(negedge clk) slow <= 1'($urandom_range(1));
  eqs_top i_dut (.clk(clk), .rst_b(rst_b), .queue_prio(queue_prio),
    .queue_weight({NQ{8'h01}}), .refill_threshold(24'sh000000),
    .ifg_bytes(8'h0c), .bucket_cap(24'sh001000),
    .cell_size_bytes(16'h00c0), .sched_disable(sched_disable),
    .enq_enable(enq_enable), .drain_req(drain_req),
    .queue_shaper_ok(queue_shaper_ok), .prio_shaper_ok(prio_shaper_ok),
    .prio_pause(prio_pause), .prio_halt(prio_halt), .enq_valid(enq_valid),
    .enq(enq), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .done_valid(done_valid), .done(done), .queue_depth(queue_depth),
    .port_depth(port_depth), .free_cells(free_cells),
    .min_free_cells(min_free_cells), .port_empty(port_empty),
    .qoff_drop_cnt(qoff_drop_cnt), .drain_drop_cnt(drain_drop_cnt));
  eqs_store i_store (.clk(clk), .rst_b(rst_b), .slow(slow),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .done_valid(done_valid), .done(done));
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // lowest priority number wins; ties unused here
  function automatic logic [QW-1:0] exp_q();
    int best;
    logic [QW-1:0] r;
    best = 8;
    r = '0;
    for (int q = 0; q < NQ; q++) begin
      if (dep[q] > 0 && !sched_disable[q] && queue_shaper_ok[q] &&
          prio_shaper_ok[queue_prio[q]] && !prio_pause[queue_prio[q]] &&
          !prio_halt[queue_prio[q]] && queue_prio[q] < best) begin
        best = queue_prio[q];
        r = QW'(q);
      end
    end
    return r;
  endfunction
  function automatic int fexp();
    int s;
    s = 1024;
    for (int q = 0; q < NQ; q++) s -= dep[q] * (q + 1);
    return s;
  endfunction
  function automatic int pexp();
    int s;
    s = 0;
    for (int q = 0; q < NQ; q++) s += dep[q];
    return s;
  endfunction
  always @(posedge clk) begin
    if (cmd_valid && cmd_ready) begin
      if (chk_on) chk(cmd.queue === exp_q(), "queue choice");
      seen.push_back(cmd.queue);
      if (dep[cmd.queue] > 0) dep[cmd.queue]--;
    end
  end
  task automatic put(input int q);
    enq_valid = 1'b1;
    enq = {QW'(q), CELL_W'(q + 1)};
    if (enq_enable[q]) dep[q]++;
    else qoff++;
    @(negedge clk);
  endtask
  task automatic settle();
    int idle;
    int n;
    idle = 0;
    n = 0;
    while (idle < 20 && n < 4000) begin
      @(negedge clk);
      n++;
      idle = cmd_valid ? 0 : idle + 1;
    end
    chk(idle >= 20, "no settle");
  endtask
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    void'($urandom(34482));
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk(free_cells === TOTAL_CELLS, "reset free");
    chk(min_free_cells === TOTAL_CELLS, "reset low");
    chk(port_empty === 1'b1, "reset empty");
    queue_prio = {NQ{3'h2}};
    repeat (2) begin
      put(0);
      put(1);
    end
    enq_valid = 1'b0;
    mn = fexp();
    sched_disable = 8'h00;
    settle();
    for (int i = 0; i < 4; i++) chk(seen[i] === QW'(i % 2), "dwrr");
    repeat (3) begin
      sched_disable = 8'hff;
      enq_enable = 8'($urandom) | 8'h81;
      // one shared offset keeps every queue on its own priority
      rot = $urandom_range(7);
      for (int q = 0; q < NQ; q++) queue_prio[q] = PW'(q + rot);
      repeat (24) put($urandom_range(7));
      enq_valid = 1'b0;
      @(negedge clk);
      if (fexp() < mn) mn = fexp();
      for (int q = 0; q < NQ; q++)
        chk(queue_depth[q] === PKT_W'(dep[q]), "depth");
      chk(free_cells === CELL_W'(fexp()), "free");
      chk(port_depth === (PKT_W + QW)'(pexp()), "port depth");
      chk(qoff_drop_cnt === CNT_W'(qoff), "qoff");
      queue_shaper_ok = ~(8'h01 << $urandom_range(7));
      prio_shaper_ok = ~(8'h01 << $urandom_range(7));
      prio_pause = 8'h01 << $urandom_range(7);
      prio_halt = 8'h01 << $urandom_range(7);
      sched_disable = 8'h01 << $urandom_range(7);
      chk_on = 1'b1;
      settle();
      chk_on = 1'b0;
      for (int q = 0; q < NQ; q++)
        chk(queue_depth[q] === PKT_W'(dep[q]), "kept");
      enq_enable = 8'h00;
      for (int q = 0; q < NQ; q++) dd += dep[q];
      drain_req = 1'b1;
      settle();
      drain_req = 1'b0;
      chk(port_empty === 1'b1, "drained");
      chk(drain_drop_cnt === CNT_W'(dd), "drain count");
      chk(min_free_cells === CELL_W'(mn), "low mark");
    end
    finish_test();
  end
endmodule
